// File: design/oec_en_sync.sv
// per-output enable synchroniser stepping on the output clock tick
`timescale 1ns/1ps
`include "oec_regs.svh"
module oec_en_sync #(
	parameter int N = `OEC_N_OUT,
	parameter int LAT = `OEC_OE_LAT_TYP
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	// enables
	input wire logic [N-1:0] en_in,
	output logic [N-1:0] en_out
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic [LAT-1:0] pipe_q;
			// steps only on the tick so an enable change never starts a pair mid cycle
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pipe_q <= '0;
				end else if (tick) begin
					pipe_q <= {pipe_q[LAT-2:0], en_in[i]};
				end
			end
			assign en_out[i] = pipe_q[LAT-1];
		end
	endgenerate
endmodule

// File: design/oec_top.sv
// output enable control: straps, registers, side-band shifter and output gating
`timescale 1ns/1ps
`include "oec_regs.svh"
// Behaviour
// - slave address comes from two three-level straps, nine values d8 to ce
// - power-good low holds all pairs low/low; first high starts, later highs resume
// - interface strap picks side-band (high) or pins plus enable bits (low), never both
// - traditional: output runs when its enable bit is 1 and, for outputs 5-12, its pin low
// - side-band: output runs when keep-on mask or output register bit is 1
// - side-band: pins 7-9,11,12 ignored; pins 5,6,10 are data, clock, load
// - load high: shift data in on each rising side-band clock
// - falling load edge copies shift register into output register
// - side-band clock at most 10 MHz; device accepts any rate up to it
// - load low: clock and data activity ignored
// - side-band works from power-on, even during power-down
// - registers are not accessible while power-good is low
// - output register and enable bits reset to enabled
// - keep-on mask bits reset to zero
// - status byte 4 reports the selected interface
// - both interfaces feed one glitch-free enable synchroniser
// - an output starts or stops within 10 output clocks of its enable change
module oec_top #(
	parameter int N_OUT = `OEC_N_OUT,
	parameter int OUT_DIV = `OEC_OUT_DIV,
	parameter int OE_LAT = `OEC_OE_LAT_TYP
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// pins
	input wire oec_pkg::oec_strap_t strap,
	input wire logic power_good_down_n,
	input wire logic [`OEC_N_PIN-1:0] oe_n,
	// register port
	input wire oec_pkg::oec_req_t req,
	output logic [7:0] rdata,
	// status
	output logic [7:0] smbus_addr,
	output logic sb_mode,
	// output pairs
	output logic [N_OUT-1:0] q_p,
	output logic [N_OUT-1:0] q_n
);
	import oec_pkg::*;

	localparam int NS = $bits(oec_strap_t) + 1 + `OEC_N_PIN;

	logic [1:0] rst_q;
	logic rst_n;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// pins come from other domains; first stage feeds only the second
	logic [NS-1:0] s1_q, s2_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {strap, power_good_down_n, oe_n};
			s2_q <= s1_q;
		end
	end

	wire oec_strap_t strap_s = s2_q[NS-1 -: $bits(oec_strap_t)];
	wire pg_s = s2_q[`OEC_N_PIN];
	wire [`OEC_N_PIN-1:0] oe_n_s = s2_q[`OEC_N_PIN-1:0];

	// power sequencing
	oec_pwr_t pwr_q, pwr_d;
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			OEC_PWR_WAIT: if (pg_s) pwr_d = OEC_PWR_RUN;
			OEC_PWR_RUN: if (!pg_s) pwr_d = OEC_PWR_DOWN;
			OEC_PWR_DOWN: if (pg_s) pwr_d = OEC_PWR_RUN;
			default: pwr_d = OEC_PWR_WAIT;
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= OEC_PWR_WAIT;
		end else begin
			pwr_q <= pwr_d;
		end
	end
	wire started = (pwr_q != OEC_PWR_WAIT);
	wire pg_on = (pwr_q == OEC_PWR_RUN);
	wire start_now = (pwr_q == OEC_PWR_WAIT) && pg_s;

	function automatic logic [7:0] addr_of(input logic [1:0] hi, input logic [1:0] lo);
		logic [3:0] code;
		code = {hi, lo};
		case (code)
			{OEC_LVL_LOW, OEC_LVL_LOW}: addr_of = `OEC_ADDR_LL;
			{OEC_LVL_LOW, OEC_LVL_MID}: addr_of = `OEC_ADDR_LM;
			{OEC_LVL_LOW, OEC_LVL_HIGH}: addr_of = `OEC_ADDR_LH;
			{OEC_LVL_MID, OEC_LVL_LOW}: addr_of = `OEC_ADDR_ML;
			{OEC_LVL_MID, OEC_LVL_MID}: addr_of = `OEC_ADDR_MM;
			{OEC_LVL_MID, OEC_LVL_HIGH}: addr_of = `OEC_ADDR_MH;
			{OEC_LVL_HIGH, OEC_LVL_LOW}: addr_of = `OEC_ADDR_HL;
			{OEC_LVL_HIGH, OEC_LVL_MID}: addr_of = `OEC_ADDR_HM;
			{OEC_LVL_HIGH, OEC_LVL_HIGH}: addr_of = `OEC_ADDR_HH;
			default: addr_of = `OEC_ADDR_HH;
		endcase
	endfunction

	// straps are caught once, at the first power-good high
	logic [7:0] addr_q;
	logic mode_q;
	wire [7:0] addr_live = addr_of(strap_s.addr_hi, strap_s.addr_lo);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= `OEC_ADDR_LL;
			mode_q <= 1'b0;
		end else if (start_now) begin
			addr_q <= addr_live;
			mode_q <= strap_s.iface_select_strap;
		end
	end
	// before start the live strap decides, so side-band can be preloaded
	assign sb_mode = started ? mode_q : strap_s.iface_select_strap;
	assign smbus_addr = addr_q;

	// side-band link on pins 5, 6 and 10
	wire sb_data = oe_n_s[`OEC_PIN_SB_DATA];
	wire sb_clk = oe_n_s[`OEC_PIN_SB_CLK];
	wire sb_load = oe_n_s[`OEC_PIN_SB_LOAD];
	logic sb_clk_q, sb_load_q;
	logic [N_OUT-1:0] shift_q, outreg_q;
	// 10 MHz gives 20 samples a period, ample for edge finding
	wire sb_rise = sb_clk && !sb_clk_q && sb_load && sb_mode;
	wire sb_fall = !sb_load && sb_load_q && sb_mode;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sb_clk_q <= 1'b0;
			sb_load_q <= 1'b0;
			shift_q <= `OEC_RST_OUTREG;
			outreg_q <= `OEC_RST_OUTREG;
		end else begin
			sb_clk_q <= sb_clk;
			sb_load_q <= sb_load;
			// first bit shifted lands at output 0 after 20 clocks
			if (sb_rise) begin
				shift_q <= {sb_data, shift_q[N_OUT-1:1]};
			end
			if (sb_fall) begin
				outreg_q <= shift_q;
			end
		end
	end

	// register file
	logic [N_OUT-1:0] en_q, mask_q;
	logic [7:0] rdata_q;
	wire acc_ok = pg_on;
	wire wr_ok = req.wr && acc_ok;
	wire [7:0] wb = req.wdata;
	wire hit_en0 = (req.addr == `OEC_OFS_EN0);
	wire hit_en1 = (req.addr == `OEC_OFS_EN1);
	wire hit_en2 = (req.addr == `OEC_OFS_EN2);
	wire hit_st = (req.addr == `OEC_OFS_STATUS);
	wire hit_m0 = (req.addr == `OEC_OFS_MASK0);
	wire hit_m1 = (req.addr == `OEC_OFS_MASK1);
	wire hit_m2 = (req.addr == `OEC_OFS_MASK2);
	wire [7:0] st_byte = {7'h00, sb_mode};
	wire [7:0] en2_byte = {4'h0, en_q[19:16]};
	wire [7:0] m2_byte = {4'h0, mask_q[19:16]};
	wire [7:0] rd_mux = !acc_ok ? 8'h00 :
		hit_en0 ? en_q[7:0] :
		hit_en1 ? en_q[15:8] :
		hit_en2 ? en2_byte :
		hit_st ? st_byte :
		hit_m0 ? mask_q[7:0] :
		hit_m1 ? mask_q[15:8] :
		hit_m2 ? m2_byte : 8'h00;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= `OEC_RST_EN;
			mask_q <= `OEC_RST_MASK;
			rdata_q <= 8'h00;
		end else begin
			if (wr_ok && hit_en0) en_q[7:0] <= wb;
			if (wr_ok && hit_en1) en_q[15:8] <= wb;
			if (wr_ok && hit_en2) en_q[19:16] <= wb[3:0];
			if (wr_ok && hit_m0) mask_q[7:0] <= wb;
			if (wr_ok && hit_m1) mask_q[15:8] <= wb;
			if (wr_ok && hit_m2) mask_q[19:16] <= wb[3:0];
			if (req.rd) rdata_q <= rd_mux;
		end
	end
	assign rdata = rdata_q;

	// per-output enable decision
	logic [N_OUT-1:0] pin_ok, en_vec;
	genvar i;
	generate
		for (i = 0; i < N_OUT; i++) begin : g_out
			if (i >= `OEC_PIN_FIRST && i <= `OEC_PIN_LAST) begin : g_pin
				assign pin_ok[i] = !oe_n_s[i-`OEC_PIN_FIRST];
			end else begin : g_nopin
				assign pin_ok[i] = 1'b1;
			end
			assign en_vec[i] = sb_mode ? (mask_q[i] | outreg_q[i]) :
				(en_q[i] & pin_ok[i]);
		end
	endgenerate

	// output clock rate as a tick from a divider
	logic [$clog2(OUT_DIV+1)-1:0] div_q;
	logic phase_q;
	wire tick = (div_q == '0);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			phase_q <= 1'b0;
		end else begin
			div_q <= tick ? ($clog2(OUT_DIV+1))'(OUT_DIV - 1) : div_q - 1'b1;
			if (tick) phase_q <= !phase_q;
		end
	end

	logic [N_OUT-1:0] en_sync;
	oec_en_sync #(.N(N_OUT), .LAT(OE_LAT)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick),
		.en_in(en_vec),
		.en_out(en_sync)
	);

	logic [N_OUT-1:0] run_q, qp_q, qn_q;
	wire [N_OUT-1:0] run_d = en_sync & {N_OUT{pg_on}};
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= '0;
			qp_q <= '0;
			qn_q <= '0;
		end else begin
			run_q <= run_d;
			qp_q <= run_d & {N_OUT{!phase_q}};
			qn_q <= run_d & {N_OUT{phase_q}};
		end
	end
	assign q_p = qp_q;
	assign q_n = qn_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_PD_LOW: assert property (
		!pg_on |=> (q_p == '0) && (q_n == '0))
		else $error("outputs not low/low in power-down");
	AST_ADDR_HELD: assert property (
		started && $past(started) |-> $stable(addr_q))
		else $error("slave address moved after start");
	AST_TRAD_PIN: assert property (
		!sb_mode && oe_n_s[0] |-> !en_vec[`OEC_PIN_FIRST])
		else $error("pin high did not disable output");
	AST_SB_MASK: assert property (
		sb_mode && mask_q[0] |-> en_vec[0])
		else $error("mask bit did not force enable");
	AST_SHIFT: assert property (
		sb_rise |=> shift_q == {$past(sb_data), $past(shift_q[N_OUT-1:1])})
		else $error("shift register did not shift");
	AST_LOAD: assert property (
		sb_fall |=> outreg_q == $past(shift_q))
		else $error("output register not loaded");
	AST_IGNORE: assert property (
		!sb_load |=> $stable(shift_q))
		else $error("shift register moved while load low");
	AST_LOCKED: assert property (
		!pg_on && req.wr |=> $stable(mask_q) && $stable(en_q))
		else $error("register written during power-down");
	AST_STATUS: assert property (
		req.rd && pg_on && hit_st |=> rdata[0] == $past(sb_mode))
		else $error("status bit wrong");
	AST_LATENCY: assert property (
		$rose(en_vec[8]) |-> ##[1:22] (run_q[8] || !en_vec[8] || !pg_on))
		else $error("output did not start in time");
endmodule

// File: inc/oec_pkg.sv
// types shared by the output enable control design
package oec_pkg;
	typedef enum logic [1:0] {
		OEC_LVL_LOW,
		OEC_LVL_MID,
		OEC_LVL_HIGH
	} oec_lvl_t;

	typedef struct packed {
		logic [1:0] addr_hi;
		logic [1:0] addr_lo;
		logic iface_select_strap;
	} oec_strap_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} oec_req_t;

	typedef enum {
		OEC_PWR_WAIT,
		OEC_PWR_RUN,
		OEC_PWR_DOWN
	} oec_pwr_t;
endpackage

// File: inc/oec_regs.svh
// register offsets, reset values and timing counts for output enable control
`ifndef OEC_REGS_SVH
`define OEC_REGS_SVH

`define OEC_N_OUT 20
`define OEC_N_PIN 8
`define OEC_PIN_FIRST 5
`define OEC_PIN_LAST 12
`define OEC_PIN_SB_DATA 0
`define OEC_PIN_SB_CLK 1
`define OEC_PIN_SB_LOAD 5

`define OEC_OFS_EN0 8'h00
`define OEC_OFS_EN1 8'h01
`define OEC_OFS_EN2 8'h02
`define OEC_OFS_STATUS 8'h04
`define OEC_OFS_MASK0 8'h08
`define OEC_OFS_MASK1 8'h09
`define OEC_OFS_MASK2 8'h0a
`define OEC_STATUS_SB_BIT 0

`define OEC_RST_EN 20'hfffff
`define OEC_RST_OUTREG 20'hfffff
`define OEC_RST_MASK 20'h00000

`define OEC_ADDR_LL 8'hd8
`define OEC_ADDR_LM 8'hda
`define OEC_ADDR_LH 8'hde
`define OEC_ADDR_ML 8'hc2
`define OEC_ADDR_MM 8'hc4
`define OEC_ADDR_MH 8'hc6
`define OEC_ADDR_HL 8'hca
`define OEC_ADDR_HM 8'hcc
`define OEC_ADDR_HH 8'hce

`define OEC_CLK_NS 5
`define OEC_SB_PERIOD_NS 100
`define OEC_SB_PERIOD_CYC (`OEC_SB_PERIOD_NS / `OEC_CLK_NS)
`define OEC_OE_LAT_TYP 5
`define OEC_OE_LAT_MAX 10
`define OEC_OUT_DIV 2

`endif

// File: tb/oec_sb_host.sv
// side-band controller model: data, clock and shift_load_n
`timescale 1ns/1ps
module oec_sb_host (
	// side-band pins
	output logic sd,
	output logic sclk,
	output logic sload
);
	initial begin
		sd = 1'b0;
		sclk = 1'b0;
		sload = 1'b0;
	end

	// one frame of exactly 20 bits, output 0 first; half sets the rate
	// nonblocking: a change landing on a clock edge is sampled after it
	task automatic send(input logic [19:0] v, input int half);
		sload <= 1'b1;
		#(half);
		for (int i = 0; i < 20; i++) begin
			sd <= v[i];
			#(half);
			sclk <= 1'b1;
			#(half);
			sclk <= 1'b0;
		end
		// released data falls to its pull-down
		sd <= 1'b0;
		#(half);
		sload <= 1'b0;
		#(half);
	endtask

	// traffic for another device sharing clock and data
	task automatic flutter();
		for (int i = 0; i < 8; i++) begin
			sd <= i[0];
			sclk <= 1'b1;
			#32;
			sclk <= 1'b0;
			#32;
		end
		sd <= 1'b0;
	endtask
endmodule

// File: tb/tb.sv
// self-checking bench for output enable control
`timescale 1ns/1ps
`include "oec_regs.svh"
module tb;
	import oec_pkg::*;
	logic clock;
	logic reset_n;
	oec_strap_t strap;
	logic power_good_down_n;
	logic [7:0] oe_tb;
	oec_req_t req;
	logic [7:0] rdata;
	logic [7:0] smbus_addr;
	logic sb_mode;
	logic [19:0] q_p;
	logic [19:0] q_n;
	logic sd;
	logic sclk;
	logic sload;
	int mismatches;
	int samples_checked;
	// side-band pins take over bits 0, 1 and 5 when selected
	wire logic [7:0] oe_n_w = strap.iface_select_strap ?
		{oe_tb[7:6], sload, oe_tb[4:2], sclk, sd} : oe_tb;

	oec_top dut (.clock(clock), .reset_n(reset_n), .strap(strap),
		.power_good_down_n(power_good_down_n), .oe_n(oe_n_w), .req(req), .rdata(rdata),
		.smbus_addr(smbus_addr), .sb_mode(sb_mode), .q_p(q_p), .q_n(q_n));
	oec_sb_host sb (.sd(sd), .sclk(sclk), .sload(sload));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic wrap_up();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		req <= '0;
		#1 chk({12'h000, rdata}, {12'h000, exp});
	endtask

	// running pairs toggle within two cycles, stopped pairs sit at 0/0
	task automatic outs(input logic [19:0] exp);
		logic [19:0] a;
		repeat (22) @(posedge clock);
		#1 a = q_p;
		repeat (2) @(posedge clock);
		#1 chk(a ^ q_p, exp);
		chk((q_p | q_n) & ~exp, 20'h00000);
	endtask

	task automatic boot(input oec_strap_t s, input logic pg);
		@(posedge clock);
		reset_n <= 1'b0;
		strap <= s;
		power_good_down_n <= pg;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
	endtask

	// the whole sequence takes well under 40 us
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end

	initial begin
		logic [7:0] at [9];
		logic [7:0] ofs [8];
		logic [7:0] ev [8];
		mismatches = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		strap = '0;
		power_good_down_n = 1'b0;
		oe_tb = 8'h00;
		req = '0;
		at = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
		ofs = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h09, 8'h0a, 8'h03};
		ev = '{8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			boot('{2'(i / 3), 2'(i % 3), 1'b0}, 1'b0);
			@(posedge clock) power_good_down_n <= 1'b1;
			repeat (8) @(posedge clock);
			chk({12'h000, smbus_addr}, {12'h000, at[i]});
		end
		wr(`OEC_OFS_STATUS, 8'hff);
		for (int i = 0; i < 8; i++) begin
			rd(ofs[i], ev[i]);
		end
		outs(20'hfffff);
		wr(`OEC_OFS_EN0, 8'hf0);
		wr(`OEC_OFS_EN2, 8'hf3);
		oe_tb <= 8'h81;
		rd(`OEC_OFS_EN2, 8'h03);
		outs(20'h3efd0);
		@(posedge clock) power_good_down_n <= 1'b0;
		outs(20'h00000);
		wr(`OEC_OFS_EN1, 8'h00);
		rd(`OEC_OFS_EN0, 8'h00);
		@(posedge clock) power_good_down_n <= 1'b1;
		outs(20'h3efd0);
		boot('{2'd0, 2'd0, 1'b1}, 1'b0);
		oe_tb <= 8'hdc;
		rd(`OEC_OFS_STATUS, 8'h00);
		sb.send(20'h0a5c3, 32);
		@(posedge clock) power_good_down_n <= 1'b1;
		outs(20'h0a5c3);
		rd(`OEC_OFS_STATUS, 8'h01);
		chk({19'h00000, sb_mode}, 20'h00001);
		wr(`OEC_OFS_EN0, 8'h00);
		wr(`OEC_OFS_MASK0, 8'h0f);
		wr(`OEC_OFS_MASK2, 8'h08);
		sb.send(20'h00000, 32);
		outs(20'h8000f);
		sb.flutter();
		outs(20'h8000f);
		sb.send(20'hfff00, 32);
		outs(20'hfff0f);
		wrap_up();
	end
endmodule
